// *** src/usb_device_state_control_regs.vh ***
// Contract
// - Pullup connects only when pullup_on set
// - Bus reset end sets unmaskable flag, interrupt
// - Bus reset end restores mask, endpoint registers
// - Address state enable, address, function enable
// - Idle bus sets suspend flag; clear register
// - Resume detected while frozen; pullup stays
// - Bus resume sets wakeup flag, masked interrupt
// - K state starts within 10 ms
// - K state lasts between 1 and 15 ms
// - K state only on send_resume rising
// - K state generated and released autonomously
// - Rising send_resume ignored unless remote wake enabled
// - Data transfers only while function_enable set
`ifndef USB_DEVICE_STATE_CONTROL_REGS_VH
`define USB_DEVICE_STATE_CONTROL_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_GLOBAL_STATE  8'h04
`define OFF_FUNC_ADDR     8'h08
`define OFF_IRQ_ENABLE    8'h10
`define OFF_IRQ_DISABLE   8'h14
`define OFF_IRQ_MASK      8'h18
`define OFF_IRQ_STATUS    8'h1c
`define OFF_IRQ_CLEAR     8'h20
`define OFF_EP_CSR_FIRST  8'h30
`define OFF_EP_CSR_LAST   8'h4c
`define OFF_XCVR_CTRL     8'h74
`define OFF_LINE_STATUS   8'h78

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GLB_ADDR_EN_BIT   0
`define GLB_CONFIG_BIT    1
`define GLB_RESUME_BIT    2
`define GLB_RSM_PROG_BIT  3
`define GLB_RWAKE_EN_BIT  4
`define FADDR_FEN_BIT     8
`define IRQ_SUSPEND_BIT   8
`define IRQ_BUSRST_BIT    12
`define IRQ_WAKEUP_BIT    13
`define IRQ_IMPL_MASK     16'h2fff
`define XCVR_DIS_BIT      8
`define XCVR_PULLUP_BIT   9
`define CSR_RW_MASK       16'h8700

// ----------------------------------------------------------------
// Reset values and response codes
// ----------------------------------------------------------------
`define IMR_RESET         16'h1200
`define FADDR_ADDR_RESET  7'h00
`define FEN_RESET         1'b1
`define XCVR_DIS_RESET    1'b1
`define RWAKE_EN_RESET    1'b1
`define CSR_RESET         16'h0000
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ           100
`define BUS_RESET_NS      2500
`define BUS_RESET_CYCLES  20'h000fa
`define SUSPEND_IDLE_US   3000
`define SUSPEND_CYCLES    20'h493e0
`define RESUME_K_US       10000
`define RESUME_K_CYCLES   20'hf4240

`endif

// *** src/bus_state_monitor.v ***
`timescale 1ns/1ps
`include "usb_device_state_control_regs.vh"
module bus_state_monitor #(
    parameter [19:0] RESET_CYCLES   = `BUS_RESET_CYCLES,
    parameter [19:0] SUSPEND_CYCLES = `SUSPEND_CYCLES
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    // Line state
    input  wire        xcvr_off,
    input  wire        line_se0,
    input  wire        line_j,
    input  wire        line_k,
    // Events
    output reg         bus_reset_end,
    output reg         suspend_event,
    output reg         resume_event,
    output reg         suspended
);

reg [19:0] se0_cnt_r;
reg [19:0] idle_cnt_r;
reg        wake_seen_r;

// ----------------------------------------------------------------
// Resume capture, runs while the rest is frozen
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn)
        wake_seen_r <= 1'b0;
    else if (!suspended)
        wake_seen_r <= 1'b0;
    else if (line_k)
        wake_seen_r <= 1'b1;
end

// ----------------------------------------------------------------
// Bus reset, idle and suspend tracking
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        se0_cnt_r     <= 20'h00000;
        idle_cnt_r    <= 20'h00000;
        bus_reset_end <= 1'b0;
        suspend_event <= 1'b0;
        resume_event  <= 1'b0;
        suspended     <= 1'b0;
    end else if (clk_en) begin
        bus_reset_end <= 1'b0;
        suspend_event <= 1'b0;
        resume_event  <= 1'b0;
        if (xcvr_off) begin
            se0_cnt_r <= 20'h00000;
        end else if (line_se0) begin
            if (se0_cnt_r < RESET_CYCLES)
                se0_cnt_r <= se0_cnt_r + 20'h00001;
        end else begin
            se0_cnt_r <= 20'h00000;
            if (se0_cnt_r >= RESET_CYCLES) begin
                bus_reset_end <= 1'b1;
                suspended     <= 1'b0;
            end
        end
        if (xcvr_off || !line_j || suspended) begin
            idle_cnt_r <= 20'h00000;
        end else if (idle_cnt_r == SUSPEND_CYCLES - 20'h00001) begin
            idle_cnt_r    <= 20'h00000;
            suspend_event <= 1'b1;
            suspended     <= 1'b1;
        end else begin
            idle_cnt_r <= idle_cnt_r + 20'h00001;
        end
        if (suspended && wake_seen_r) begin
            resume_event <= 1'b1;
            suspended    <= 1'b0;
        end
    end
end

endmodule // bus_state_monitor

// *** src/remote_wake_driver.v ***
`timescale 1ns/1ps
`include "usb_device_state_control_regs.vh"
module remote_wake_driver #(
    parameter [19:0] K_CYCLES = `RESUME_K_CYCLES
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    // Control
    input  wire        start,
    // Line drive
    output reg         k_drive
);

localparam [1:0] ST_IDLE  = 2'b01;
localparam [1:0] ST_DRIVE = 2'b10;

reg [1:0]  state_r;
reg [19:0] cnt_r;

// ----------------------------------------------------------------
// K state sequencer
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        state_r <= ST_IDLE;
        cnt_r   <= 20'h00000;
        k_drive <= 1'b0;
    end else if (clk_en) begin
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_r <= ST_DRIVE;
                    k_drive <= 1'b1;
                    cnt_r   <= 20'h00000;
                end
            end
            ST_DRIVE: begin
                if (cnt_r == K_CYCLES - 20'h00001) begin
                    state_r <= ST_IDLE;
                    k_drive <= 1'b0;
                end else begin
                    cnt_r <= cnt_r + 20'h00001;
                end
            end
            default: begin
                state_r <= ST_IDLE;
                k_drive <= 1'b0;
            end
        endcase
    end
end

endmodule // remote_wake_driver

// *** src/usb_device_state_control.v ***
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "usb_device_state_control_regs.vh"
module usb_device_state_control #(
    parameter [19:0] SUSPEND_CYCLES  = `SUSPEND_CYCLES,
    parameter [19:0] RESUME_K_CYCLES = `RESUME_K_CYCLES
) (
    // Clock, reset, enable
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    // AXI4-Lite write address
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // USB line state
    input  wire        line_se0,
    input  wire        line_j,
    input  wire        line_k,
    // USB line control
    output wire        resume_k_drive,
    output reg         pullup_on,
    output reg         transceiver_disable,
    // Device state
    output reg  [6:0]  usb_address,
    output reg         function_enable,
    output reg         configured,
    output reg         irq
);

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg         aw_hold_r;
reg  [7:0]  aw_addr_r;
reg         w_hold_r;
reg  [31:0] w_data_r;
reg  [3:0]  w_strb_r;
reg         addr_state_r;
reg         send_resume_r;
reg         remote_wake_en_r;
reg  [6:0]  func_addr_r;
reg  [15:0] irq_mask_r;
reg         suspend_flag_r;
reg         wakeup_flag_r;
reg         bus_reset_end_flag_r;
reg  [15:0] ep_csr_r [0:7];
reg         wake_start_r;
reg  [31:0] rd_data;
reg  [1:0]  rd_resp;
integer     i;

wire        wr_fire;
wire [31:0] wmask;
wire [31:0] wval;
wire [15:0] irq_status;
wire        bus_reset_end;
wire        suspend_event;
wire        resume_event;
wire        suspended;
wire        wr_glb;
wire        wr_faddr;
wire        wr_ier;
wire        wr_idr;
wire        wr_icr;
wire        wr_xcvr;
wire        wr_csr;
wire [2:0]  wr_csr_idx;

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function [31:0] strb_mask;
    input [3:0] strb;
    begin
        strb_mask = {{8{strb[3]}}, {8{strb[2]}},
                     {8{strb[1]}}, {8{strb[0]}}};
    end
endfunction

function is_csr;
    input [7:0] addr;
    begin
        is_csr = (addr >= `OFF_EP_CSR_FIRST) &&
                 (addr <= `OFF_EP_CSR_LAST);
    end
endfunction

// ----------------------------------------------------------------
// Write decode
// ----------------------------------------------------------------
assign wr_fire    = aw_hold_r && w_hold_r && !s_axi_bvalid;
assign wmask      = strb_mask(w_strb_r);
assign wval       = w_data_r & wmask;
assign wr_glb     = wr_fire && (aw_addr_r == `OFF_GLOBAL_STATE);
assign wr_faddr   = wr_fire && (aw_addr_r == `OFF_FUNC_ADDR);
assign wr_ier     = wr_fire && (aw_addr_r == `OFF_IRQ_ENABLE);
assign wr_idr     = wr_fire && (aw_addr_r == `OFF_IRQ_DISABLE);
assign wr_icr     = wr_fire && (aw_addr_r == `OFF_IRQ_CLEAR);
assign wr_xcvr    = wr_fire && (aw_addr_r == `OFF_XCVR_CTRL);
assign wr_csr     = wr_fire && is_csr(aw_addr_r);
assign wr_csr_idx = aw_addr_r[4:2] - 3'h4;

assign irq_status = {2'b00, wakeup_flag_r, bus_reset_end_flag_r,
                     3'b000, suspend_flag_r, 8'h00};

// ----------------------------------------------------------------
// AXI4-Lite write channel
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_hold_r     <= 1'b0;
        aw_addr_r     <= 8'h00;
        w_hold_r      <= 1'b0;
        w_data_r      <= 32'h00000000;
        w_strb_r      <= 4'h0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `RESP_OKAY;
    end else if (clk_en) begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r     <= 1'b1;
            aw_addr_r     <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_glb || wr_faddr || wr_ier || wr_idr ||
                             wr_icr || wr_xcvr || wr_csr) ?
                            `RESP_OKAY : `RESP_DECERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
always @* begin
    rd_data = 32'h00000000;
    rd_resp = `RESP_OKAY;
    case ({s_axi_araddr[7:2], 2'b00})
        `OFF_GLOBAL_STATE:
            rd_data = {27'h0000000, remote_wake_en_r, resume_k_drive,
                       send_resume_r, configured, addr_state_r};
        `OFF_FUNC_ADDR:
            rd_data = {23'h000000, function_enable, 1'b0, func_addr_r};
        `OFF_IRQ_ENABLE,
        `OFF_IRQ_DISABLE,
        `OFF_IRQ_CLEAR:
            rd_data = 32'h00000000;
        `OFF_IRQ_MASK:
            rd_data = {16'h0000, irq_mask_r};
        `OFF_IRQ_STATUS:
            rd_data = {16'h0000, irq_status};
        `OFF_XCVR_CTRL:
            rd_data = {22'h000000, pullup_on, transceiver_disable,
                       8'h00};
        `OFF_LINE_STATUS:
            rd_data = {30'h00000000, resume_k_drive, suspended};
        default: begin
            if (is_csr({s_axi_araddr[7:2], 2'b00}))
                rd_data = {16'h0000,
                           ep_csr_r[s_axi_araddr[4:2] - 3'h4]};
            else
                rd_resp = `RESP_DECERR;
        end
    endcase
end

// ----------------------------------------------------------------
// AXI4-Lite read channel
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `RESP_OKAY;
    end else if (clk_en) begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Control and status registers
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        addr_state_r         <= 1'b0;
        configured           <= 1'b0;
        send_resume_r        <= 1'b0;
        remote_wake_en_r     <= `RWAKE_EN_RESET;
        func_addr_r          <= `FADDR_ADDR_RESET;
        function_enable      <= `FEN_RESET;
        irq_mask_r           <= `IMR_RESET;
        suspend_flag_r       <= 1'b0;
        wakeup_flag_r        <= 1'b0;
        bus_reset_end_flag_r <= 1'b0;
        pullup_on            <= 1'b0;
        transceiver_disable  <= `XCVR_DIS_RESET;
        wake_start_r         <= 1'b0;
        usb_address          <= 7'h00;
        irq                  <= 1'b0;
        for (i = 0; i < 8; i = i + 1)
            ep_csr_r[i] <= `CSR_RESET;
    end else if (clk_en) begin
        wake_start_r <= 1'b0;
        if (wr_glb) begin
            if (wval[`GLB_ADDR_EN_BIT])
                addr_state_r <= 1'b1;
            if (wmask[`GLB_CONFIG_BIT])
                configured <= w_data_r[`GLB_CONFIG_BIT];
            if (wmask[`GLB_RWAKE_EN_BIT])
                remote_wake_en_r <= w_data_r[`GLB_RWAKE_EN_BIT];
            if (wmask[`GLB_RESUME_BIT]) begin
                send_resume_r <= w_data_r[`GLB_RESUME_BIT];
                wake_start_r  <= w_data_r[`GLB_RESUME_BIT] &&
                                 !send_resume_r &&
                                 remote_wake_en_r;
            end
        end
        if (wr_faddr) begin
            func_addr_r <= (func_addr_r & ~wmask[6:0]) |
                           (w_data_r[6:0] & wmask[6:0]);
            if (wmask[`FADDR_FEN_BIT])
                function_enable <= w_data_r[`FADDR_FEN_BIT];
        end
        if (wr_ier)
            irq_mask_r <= irq_mask_r | (wval[15:0] & `IRQ_IMPL_MASK);
        if (wr_idr)
            irq_mask_r <= irq_mask_r & ~(wval[15:0] & `IRQ_IMPL_MASK);
        if (wr_xcvr) begin
            if (wmask[`XCVR_DIS_BIT])
                transceiver_disable <= w_data_r[`XCVR_DIS_BIT];
            if (wmask[`XCVR_PULLUP_BIT])
                pullup_on <= w_data_r[`XCVR_PULLUP_BIT];
        end
        if (wr_csr)
            ep_csr_r[wr_csr_idx] <= (ep_csr_r[wr_csr_idx] & ~wmask[15:0]) |
                (wval[15:0] & `CSR_RW_MASK);
        // Event flags: a set in the clearing cycle wins
        suspend_flag_r <= suspend_event ||
            (suspend_flag_r && !(wr_icr && wval[`IRQ_SUSPEND_BIT]));
        wakeup_flag_r <= resume_event ||
            (wakeup_flag_r && !(wr_icr && wval[`IRQ_WAKEUP_BIT]));
        bus_reset_end_flag_r <= bus_reset_end ||
            (bus_reset_end_flag_r &&
             !(wr_icr && wval[`IRQ_BUSRST_BIT]));
        if (bus_reset_end) begin
            irq_mask_r   <= `IMR_RESET;
            addr_state_r <= 1'b0;
            configured   <= 1'b0;
            func_addr_r  <= `FADDR_ADDR_RESET;
            for (i = 0; i < 8; i = i + 1)
                ep_csr_r[i] <= `CSR_RESET;
        end
        usb_address <= addr_state_r ? func_addr_r : 7'h00;
        irq <= |(irq_status & (irq_mask_r |
                 (16'h0001 << `IRQ_BUSRST_BIT)));
    end
end

// ----------------------------------------------------------------
// Line monitor and remote wake
// ----------------------------------------------------------------
bus_state_monitor #(
    .RESET_CYCLES   (`BUS_RESET_CYCLES),
    .SUSPEND_CYCLES (SUSPEND_CYCLES)
) u_monitor (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .clk_en        (clk_en),
    .xcvr_off      (transceiver_disable),
    .line_se0      (line_se0),
    .line_j        (line_j),
    .line_k        (line_k),
    .bus_reset_end (bus_reset_end),
    .suspend_event (suspend_event),
    .resume_event  (resume_event),
    .suspended     (suspended)
);

remote_wake_driver #(
    .K_CYCLES (RESUME_K_CYCLES)
) u_wake (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .start   (wake_start_r),
    .k_drive (resume_k_drive)
);

endmodule // usb_device_state_control

// *** verification/usb_device_state_control_sva.sv ***
`timescale 1ns/1ps
module usb_state_checker #(
    parameter [19:0] RESUME_K_CYCLES = 20'hf4240
) (
    // Clock and reset
    input wire       aclk,
    input wire       aresetn,
    input wire       clk_en,
    // Bus handshakes
    input wire       s_axi_awready,
    input wire       s_axi_bvalid,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    // Line and state
    input wire       line_se0,
    input wire       resume_k_drive,
    input wire       pullup_on,
    input wire       transceiver_disable,
    input wire [6:0] usb_address,
    input wire       function_enable,
    input wire       irq
);
    reg [15:0] se0_run;
    reg [19:0] k_run;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // --------
    // Run lengths
    // --------
    always @(posedge aclk) begin
        se0_run <= (line_se0 && aresetn) ? se0_run + 16'h1 : 16'h0;
        k_run   <= (resume_k_drive && aresetn) ? k_run + 20'h1 : 20'h0;
    end
    sequence s_reset_end;
        $fell(line_se0) && se0_run >= 16'hfa && !transceiver_disable
            && clk_en;
    endsequence
    sequence s_write_done;
        ##[0:1] s_axi_bvalid;
    endsequence
    // --------
    // Assertions
    // --------
    a_reset_idle: assert property (disable iff (1'b0)
        !aresetn |=> !pullup_on && transceiver_disable && !resume_k_drive
            && s_axi_awready && !s_axi_bvalid)
        else $error("outputs not idle after reset");
    a_pullup_write: assert property (
        $rose(pullup_on) |-> s_write_done)
        else $error("pullup rose without a write");
    a_pullup_frozen: assert property (
        !clk_en |=> $stable(pullup_on))
        else $error("pullup moved while frozen");
    a_busrst_irq: assert property (
        s_reset_end |-> ##[1:3] irq)
        else $error("no irq after bus reset end");
    a_fen_write: assert property (
        $changed(function_enable) |-> s_write_done)
        else $error("function enable moved without write");
    a_addr_write: assert property (
        $changed(usb_address) && usb_address != 7'h0 |-> $past(s_axi_bvalid))
        else $error("address moved without write");
    a_k_trigger: assert property (
        $rose(resume_k_drive) |-> $past(s_axi_bvalid)
            || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
        else $error("k drive without a write");
    a_k_length: assert property (
        $fell(resume_k_drive) |-> k_run == RESUME_K_CYCLES)
        else $error("k drive length wrong");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_busy: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("write address ready during response");
endmodule // usb_state_checker

bind usb_device_state_control usb_state_checker #(
    .RESUME_K_CYCLES(RESUME_K_CYCLES)
) checker_inst (
    .aclk, .aresetn, .clk_en, .s_axi_awready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .line_se0,
    .resume_k_drive, .pullup_on, .transceiver_disable, .usb_address,
    .function_enable, .irq
);

// *** verification/usb_host_model.sv ***
`timescale 1ns/1ps
module usb_host_model (
    // Clock
    input  wire       aclk,
    // Command: 0 idle, 1 bus reset, 2 resume, 3 traffic
    input  wire [1:0] cmd,
    // Line state
    output reg        line_se0 = 1'b0,
    output reg        line_j   = 1'b1,
    output reg        line_k   = 1'b0
);
    always @(posedge aclk) begin
        line_se0 <= (cmd == 2'h1);
        line_j   <= (cmd == 2'h0) || (cmd == 2'h3 && !line_j);
        line_k   <= (cmd == 2'h2) || (cmd == 2'h3 && line_j);
    end
endmodule // usb_host_model

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [1:0]  host_cmd = 2'h3;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid, resume_k_drive;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         line_se0, line_j, line_k, pullup_on, irq;
    wire         transceiver_disable, function_enable, configured;
    wire  [6:0]  usb_address;
    logic [31:0] rdat;
    logic [1:0]  resp;
    int          n_fail, compares, cyc, kn;
    logic [7:0]  ra [6] = '{8'h04, 8'h08, 8'h18, 8'h1c, 8'h30, 8'h74};
    logic [31:0] rv [6] = '{32'h10, 32'h100, 32'h1200, 32'h0, 32'h0,
                            32'h100};

    usb_device_state_control #(
        .SUSPEND_CYCLES(20'h32), .RESUME_K_CYCLES(20'h28)
    ) usb_device_state_control_inst (
        .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_se0, .line_j,
        .line_k, .resume_k_drive, .pullup_on, .transceiver_disable,
        .usb_address, .function_enable, .configured, .irq
    );
    usb_host_model usb_host_model_inst (
        .aclk, .cmd(host_cmd), .line_se0, .line_j, .line_k
    );

    // --------
    // Tasks
    // --------
    task chk(input string n, input [31:0] s, input [31:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= {24'h0, a};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task rc(input [7:0] a, input [31:0] e);
        rd(a);
        chk($sformatf("reg_%h", a), rdat, e);
    endtask
    task k_count;
        kn = 0;
        repeat (8) if (!resume_k_drive) @(posedge aclk);
        while (resume_k_drive) begin
            kn++;
            @(posedge aclk);
        end
    endtask
    task test_done;
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // --------
    // Clock and timeout
    // --------
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            test_done;
        end
    end

    // --------
    // Sequence
    // --------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk("pullup", 32'(pullup_on), 32'h0);
        for (int i = 0; i < 6; i++) rc(ra[i], rv[i]);
        rd(8'h0c);
        chk("unmapped", 32'(resp), 32'h3);
        wr(8'h18, 32'hffff);
        chk("ro_write", 32'(resp), 32'h3);
        wr(8'h74, 32'h200);
        chk("pullup", 32'(pullup_on), 32'h1);
        chk("xcvr_off", 32'(transceiver_disable), 32'h0);
        wr(8'h10, 32'h100);
        wr(8'h30, 32'h8000);
        wr(8'h04, 32'h3);
        chk("configured", 32'(configured), 32'h1);
        rc(8'h18, 32'h1300);
        host_cmd <= 2'h1;
        repeat (260) @(posedge aclk);
        host_cmd <= 2'h3;
        repeat (5) @(posedge aclk);
        chk("irq", 32'(irq), 32'h1);
        rc(8'h1c, 32'h1000);
        rc(8'h18, 32'h1200);
        rc(8'h30, 32'h0);
        rc(8'h04, 32'h0);
        wr(8'h20, 32'h1000);
        rc(8'h1c, 32'h0);
        chk("irq", 32'(irq), 32'h0);
        wr(8'h08, 32'h105);
        chk("address", 32'(usb_address), 32'h0);
        wr(8'h04, 32'h1);
        @(posedge aclk);
        chk("address", 32'(usb_address), 32'h5);
        wr(8'h08, 32'h5);
        chk("fen", 32'(function_enable), 32'h0);
        wr(8'h08, 32'h105);
        chk("fen", 32'(function_enable), 32'h1);
        wr(8'h10, 32'h2100);
        host_cmd <= 2'h0;
        repeat (30) @(posedge aclk);
        chk("irq", 32'(irq), 32'h0);
        repeat (30) @(posedge aclk);
        chk("irq", 32'(irq), 32'h1);
        rc(8'h1c, 32'h100);
        rc(8'h78, 32'h1);
        wr(8'h20, 32'h100);
        wr(8'h14, 32'h100);
        rc(8'h18, 32'h3200);
        rc(8'h1c, 32'h0);
        clk_en <= 1'b0;
        host_cmd <= 2'h2;
        repeat (5) @(posedge aclk);
        host_cmd <= 2'h3;
        repeat (3) @(posedge aclk);
        chk("pullup", 32'(pullup_on), 32'h1);
        clk_en <= 1'b1;
        repeat (4) @(posedge aclk);
        rc(8'h1c, 32'h2000);
        chk("irq", 32'(irq), 32'h1);
        rc(8'h78, 32'h0);
        wr(8'h20, 32'h2000);
        wr(8'h04, 32'h5);
        repeat (6) @(posedge aclk);
        chk("k_drive", 32'(resume_k_drive), 32'h0);
        wr(8'h04, 32'h11);
        wr(8'h04, 32'h15);
        k_count;
        chk("k_cycles", 32'(kn), 32'h28);
        wr(8'h04, 32'h15);
        repeat (6) @(posedge aclk);
        chk("k_drive", 32'(resume_k_drive), 32'h0);
        wr(8'h04, 32'h11);
        wr(8'h04, 32'h15);
        k_count;
        chk("k_cycles", 32'(kn), 32'h28);
        test_done;
    end
endmodule // testbench
